// ---- vic_pkg.sv ----
package vic_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_IRQ = 72;
  localparam int FLAG_REGS = 5;
  localparam int PRIO_REGS = 18;
  localparam int PRIO_PER_REG = 4;
  localparam int PRIO_FIELD = 4;
  localparam int PRIO_W = 3;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int VEC_W = 7;
  localparam int LVL_W = 4;
  localparam int TADDR_W = 24;
  localparam int EXT_N = 5;
  localparam int TRAP_N = 5;

  // ==========================================================
  // Register indices
  localparam logic [ADDR_W-1:0] IDX_GCTL1 = 6'h00;
  localparam logic [ADDR_W-1:0] IDX_GCTL2 = 6'h01;
  localparam logic [ADDR_W-1:0] IDX_FLAG0 = 6'h02;
  localparam logic [ADDR_W-1:0] IDX_EN0 = 6'h07;
  localparam logic [ADDR_W-1:0] IDX_PRIO0 = 6'h0C;
  localparam logic [ADDR_W-1:0] IDX_PEND = 6'h1E;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 6'h1F;
  localparam logic [ADDR_W-1:0] IDX_CORE = 6'h20;

  // ==========================================================
  // Field positions, masks and reset values
  localparam int NEST_BIT = 15;
  localparam int ALT_BIT = 15;
  localparam int DISI_BIT = 14;
  localparam int IPL_LSB = 5;
  localparam int IPL_MSB_BIT = 3;
  localparam int PEND_LVL_LSB = 8;
  localparam logic [DATA_W-1:0] GCTL1_WMASK = 16'hFFFE;
  localparam logic [DATA_W-1:0] GCTL2_WMASK = 16'h801F;
  localparam logic [DATA_W-1:0] PRIO_WMASK = 16'h7777;
  localparam logic [DATA_W-1:0] GCTL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] STATUS_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CORE_RST = 16'h0020;
  localparam logic [LVL_W-1:0] USER_MAX_LVL = 4'h7;

  // ==========================================================
  // Vector map
  localparam int VEC_OFS = 8;
  localparam int TRAP_VEC0 = 1;
  localparam logic [TADDR_W-1:0] TBL_BASE = 24'h000004;
  localparam logic [TADDR_W-1:0] ALT_OFS = 24'h000100;
  // External pins 0..4 in request order
  localparam int EXT_IRQ [EXT_N] = '{0, 20, 29, 53, 54};
  // Traps: osc fail, address, stack, math, DMA
  localparam int TRAP_BIT [TRAP_N] = '{1, 3, 2, 4, 5};
  localparam logic [LVL_W-1:0] TRAP_LVL [TRAP_N] = '{4'hE, 4'hD, 4'hC, 4'hB, 4'hA};
  // Named sources of the upper map
  localparam int IRQ_CODEC_ERR = 59;
  localparam int IRQ_CODEC_DONE = 60;
  localparam int IRQ_SER1_ERR = 65;
  localparam int IRQ_SER2_ERR = 66;
  localparam int IRQ_CAN1_TX = 70;
  localparam int IRQ_CAN2_TX = 71;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vec;
    logic [LVL_W-1:0] lvl;
  } vic_win_t;

  typedef struct packed {
    logic [DATA_W-1:0] gctl1;
    logic [DATA_W-1:0] gctl2;
    logic [FLAG_REGS-1:0][DATA_W-1:0] flag;
    logic [FLAG_REGS-1:0][DATA_W-1:0] en;
    logic [PRIO_REGS-1:0][DATA_W-1:0] prio;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] core;
    logic [EXT_N-1:0] pin_s1;
    logic [EXT_N-1:0] pin_s2;
    logic [EXT_N-1:0] pin_prev;
    vic_win_t pend;
    logic [TADDR_W-1:0] pend_addr;
    logic [DATA_W-1:0] rdata;
  } vic_state_t;

endpackage : vic_pkg

// ---- vic_arbiter.sv ----
`timescale 1ns/10ps
module vic_arbiter
  import vic_pkg::*;
(
  input wire logic [NUM_IRQ-1:0] req,
  input wire logic [NUM_IRQ-1:0][PRIO_W-1:0] prio,
  input wire logic [TRAP_N-1:0] trap,
  input wire logic [LVL_W-1:0] cpu_lvl,
  output vic_win_t win
);

  // ==========================================================
  // Priority search
  // Ascending scan replacing only on strictly higher level, so
  // equal levels keep the lower vector.
  always_comb begin
    logic [LVL_W-1:0] lvl;
    lvl = '0;
    win = '0;
    for (int i = 0; i < TRAP_N; i++) begin
      if (trap[i] && TRAP_LVL[i] > cpu_lvl && (!win.valid || TRAP_LVL[i] > win.lvl)) begin
        win.valid = 1'b1;
        win.vec = VEC_W'(i + TRAP_VEC0);
        win.lvl = TRAP_LVL[i];
      end
    end
    for (int i = 0; i < NUM_IRQ; i++) begin
      lvl = {1'b0, prio[i]};
      if (req[i] && lvl > cpu_lvl && (!win.valid || lvl > win.lvl)) begin
        win.valid = 1'b1;
        win.vec = VEC_W'(i + VEC_OFS);
        win.lvl = lvl;
      end
    end
  end

endmodule : vic_arbiter

// ---- vic_controller.sv ----
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
// Contract
// - Requests 46..71 use vectors 54..79; address twice vector plus 4, alternate +0x100.
// - Requests 59,60 codec error/done; 65,66 serial errors; 70,71 CAN transmit.
// - Trap vectors 1..5: oscillator, address, stack, math, DMA errors.
// - Thirty-one controller registers: two control, five flag, five enable, eighteen priority, pending.
// - First control register holds nesting disable and trap flags.
// - Second control register holds pin edge polarity and alternate table select.
// - Each source has a flag set by hardware and cleared only by software.
// - Each user source has its own enable; only enabled user sources interrupt; traps have no enable.
// - Each user source has a programmable three-bit priority.
// - Flag, enable and priority positions follow request number order.
// - Pending register latches 7-bit vector and 4-bit new level.
// - Latched new level equals priority of the pending interrupt.
// - Status bits 7:5 hold low level bits, writable by software.
// - Level top bit lives in core control, read-only to software.
// - Level is four bits; top bit set blocks all user interrupts.
// - Low bits 111 give level 7 and block all user interrupts.
// - Nesting disable makes the status level bits read-only.
// - Alternate select makes all vectors come from the alternate table.
// - Among equal requests the lower vector wins.
// - Nesting disable set stops nesting of user interrupts (ack sets level 7), traps still nest; clear allows it.
// - Polarity bit 1 selects falling edge, 0 rising edge.
module vic_controller
  import vic_pkg::*;
#(
  parameter int IRQ_COUNT = NUM_IRQ
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic [NUM_IRQ-1:0] irq_set,
  input wire logic [EXT_N-1:0] ext_pin,
  input wire logic [TRAP_N-1:0] trap_set,
  input wire logic disi_active,
  input wire logic core_ack,
  input wire logic lvl_restore,
  input wire logic [LVL_W-1:0] lvl_restore_val,
  output logic pend_valid,
  output logic [VEC_W-1:0] pend_vec,
  output logic [LVL_W-1:0] pend_lvl,
  output logic [TADDR_W-1:0] pend_addr,
  output logic [LVL_W-1:0] cpu_priority_level
);

  // ==========================================================
  // Elaboration check
  if (IRQ_COUNT != NUM_IRQ || NUM_IRQ > FLAG_REGS * DATA_W || NUM_IRQ > PRIO_REGS * PRIO_PER_REG) begin : g_chk
    $error("vic_controller: request count does not fit the register set");
  end

  // Named upper-map sources must land inside the request range
  if (IRQ_CAN2_TX >= NUM_IRQ || IRQ_CODEC_ERR >= NUM_IRQ) begin : g_chk_map
    $error("vic_controller: named source outside the request range");
  end

  // ==========================================================
  // Helpers
  function automatic logic [TADDR_W-1:0] vec_addr(input logic [VEC_W-1:0] v, input logic alt);
    logic [TADDR_W-1:0] a;
    a = TBL_BASE + (TADDR_W'(v) << 1);
    if (alt) begin
      a = a + ALT_OFS;
    end
    return a;
  endfunction : vec_addr

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] nw,
                                              input logic [DATA_W-1:0] mask);
    return (old & ~mask) | (nw & mask);
  endfunction : merge

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base, input int n,
                               output int idx);
    idx = int'(a) - int'(base);
    return idx >= 0 && idx < n;
  endfunction : hit

  // ==========================================================
  // State
  vic_state_t state_reg;
  vic_state_t state_next;

  logic [NUM_IRQ-1:0] flag_vec;
  logic [NUM_IRQ-1:0] en_vec;
  logic [NUM_IRQ-1:0][PRIO_W-1:0] prio_vec;
  logic [TRAP_N-1:0] trap_vec;
  logic [LVL_W-1:0] cur_lvl;
  vic_win_t win;

  // ==========================================================
  // Flattened views in request order
  always_comb begin
    for (int i = 0; i < NUM_IRQ; i++) begin
      flag_vec[i] = state_reg.flag[i / DATA_W][i % DATA_W];
      en_vec[i] = state_reg.en[i / DATA_W][i % DATA_W];
      prio_vec[i] = state_reg.prio[i / PRIO_PER_REG][(i % PRIO_PER_REG) * PRIO_FIELD +: PRIO_W];
    end
    for (int t = 0; t < TRAP_N; t++) begin
      trap_vec[t] = state_reg.gctl1[TRAP_BIT[t]];
    end
  end

  // Level: core bit on top of status bits
  assign cur_lvl = {state_reg.core[IPL_MSB_BIT], state_reg.status[IPL_LSB +: 3]};

  vic_arbiter u_arb (
    .req(flag_vec & en_vec),
    .prio(prio_vec),
    .trap(trap_vec),
    .cpu_lvl(cur_lvl),
    .win(win)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic [EXT_N-1:0] edge_hit;
    logic [NUM_IRQ-1:0] set_vec;
    logic [TRAP_N-1:0] tset;
    int idx;
    edge_hit = '0;
    set_vec = irq_set;
    tset = trap_set;
    idx = 0;
    state_next = state_reg;

    // Pin synchroniser; only the second stage feeds edge logic
    state_next.pin_s1 = ext_pin;
    state_next.pin_s2 = state_reg.pin_s1;
    state_next.pin_prev = state_reg.pin_s2;
    for (int p = 0; p < EXT_N; p++) begin
      if (state_reg.gctl2[p]) begin
        edge_hit[p] = state_reg.pin_prev[p] & ~state_reg.pin_s2[p];
      end else begin
        edge_hit[p] = ~state_reg.pin_prev[p] & state_reg.pin_s2[p];
      end
      set_vec[EXT_IRQ[p]] = set_vec[EXT_IRQ[p]] | edge_hit[p];
    end

    // Software writes
    if (wr) begin
      if (addr == IDX_GCTL1) begin
        state_next.gctl1 = merge(state_reg.gctl1, wdata, GCTL1_WMASK);
      end
      if (addr == IDX_GCTL2) begin
        state_next.gctl2 = merge(state_reg.gctl2, wdata, GCTL2_WMASK);
      end
      if (hit(addr, IDX_FLAG0, FLAG_REGS, idx)) begin
        state_next.flag[idx] = wdata;
      end
      if (hit(addr, IDX_EN0, FLAG_REGS, idx)) begin
        state_next.en[idx] = wdata;
      end
      if (hit(addr, IDX_PRIO0, PRIO_REGS, idx)) begin
        state_next.prio[idx] = wdata & PRIO_WMASK;
      end
      if (addr == IDX_STATUS) begin
        state_next.status = wdata;
        if (state_reg.gctl1[NEST_BIT]) begin
          state_next.status[IPL_LSB +: 3] = state_reg.status[IPL_LSB +: 3];
        end
      end
      if (addr == IDX_CORE) begin
        state_next.core = wdata;
        state_next.core[IPL_MSB_BIT] = state_reg.core[IPL_MSB_BIT];
      end
    end

    // Core taking the presented vector raises the level
    if (core_ack && state_reg.pend.valid) begin
      if (state_reg.pend.lvl > USER_MAX_LVL) begin
        state_next.core[IPL_MSB_BIT] = 1'b1;
        state_next.status[IPL_LSB +: 3] = state_reg.pend.lvl[2:0];
      end else if (state_reg.gctl1[NEST_BIT]) begin
        state_next.status[IPL_LSB +: 3] = USER_MAX_LVL[2:0];
      end else begin
        state_next.status[IPL_LSB +: 3] = state_reg.pend.lvl[2:0];
      end
    end else if (lvl_restore) begin
      state_next.core[IPL_MSB_BIT] = lvl_restore_val[3];
      state_next.status[IPL_LSB +: 3] = lvl_restore_val[2:0];
    end

    // Hardware sets win over a same-cycle software clear
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (set_vec[i]) begin
        state_next.flag[i / DATA_W][i % DATA_W] = 1'b1;
      end
    end
    for (int t = 0; t < TRAP_N; t++) begin
      if (tset[t]) begin
        state_next.gctl1[TRAP_BIT[t]] = 1'b1;
      end
    end

    // Pending latch, refreshed every cycle
    state_next.pend = win;
    state_next.pend_addr = win.valid ? vec_addr(win.vec, state_reg.gctl2[ALT_BIT]) : '0;

    // Read data, one cycle after the strobe
    state_next.rdata = '0;
    if (rd) begin
      if (addr == IDX_GCTL1) begin
        state_next.rdata = state_reg.gctl1;
      end
      if (addr == IDX_GCTL2) begin
        state_next.rdata = state_reg.gctl2;
        state_next.rdata[DISI_BIT] = disi_active;
      end
      if (hit(addr, IDX_FLAG0, FLAG_REGS, idx)) begin
        state_next.rdata = state_reg.flag[idx];
      end
      if (hit(addr, IDX_EN0, FLAG_REGS, idx)) begin
        state_next.rdata = state_reg.en[idx];
      end
      if (hit(addr, IDX_PRIO0, PRIO_REGS, idx)) begin
        state_next.rdata = state_reg.prio[idx];
      end
      if (addr == IDX_PEND) begin
        state_next.rdata[PEND_LVL_LSB +: LVL_W] = state_reg.pend.lvl;
        state_next.rdata[VEC_W-1:0] = state_reg.pend.vec;
      end
      if (addr == IDX_STATUS) begin
        state_next.rdata = state_reg.status;
      end
      if (addr == IDX_CORE) begin
        state_next.rdata = state_reg.core;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.gctl1 <= GCTL_RST;
      state_reg.gctl2 <= GCTL_RST;
      state_reg.status <= STATUS_RST;
      state_reg.core <= CORE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = state_reg.rdata;
  assign pend_valid = state_reg.pend.valid;
  assign pend_vec = state_reg.pend.vec;
  assign pend_lvl = state_reg.pend.lvl;
  assign pend_addr = state_reg.pend_addr;
  assign cpu_priority_level = cur_lvl;

endmodule : vic_controller

// ---- vic_checker_sva.sv ----
`timescale 1ns/10ps
module vic_checker_sva
  import vic_pkg::*;
#(
  parameter int IRQ_COUNT = NUM_IRQ
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic core_ack,
  input wire logic lvl_restore,
  input wire logic pend_valid,
  input wire logic [VEC_W-1:0] pend_vec,
  input wire logic [LVL_W-1:0] pend_lvl,
  input wire logic [TADDR_W-1:0] pend_addr,
  input wire logic [LVL_W-1:0] cpu_priority_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // =====
  // Presentation
  a_table_addr: assert property (
    pend_valid |-> pend_addr[7:0] == {pend_vec, 1'b0} + 8'h04 && pend_addr[23:9] == '0)
    else $error("table address wrong");
  a_trap_range: assert property (
    pend_valid && pend_vec < 7'h08 |-> pend_vec inside {[1:5]} && pend_lvl >= 4'h8)
    else $error("trap vector or level wrong");
  // Pend is computed from the level of the cycle before
  a_user_above: assert property (
    pend_valid && pend_vec >= 7'h08 |-> pend_lvl > $past(cpu_priority_level) && pend_lvl <= USER_MAX_LVL)
    else $error("user interrupt not above level");
  // =====
  // Level handling
  a_user_ack_lvl: assert property (
    core_ack && pend_valid && pend_vec >= 7'h08 |=> cpu_priority_level == $past(pend_lvl) ||
    cpu_priority_level == USER_MAX_LVL)
    else $error("level after user ack wrong");
  a_trap_ack_lvl: assert property (
    core_ack && pend_valid && pend_vec < 7'h08 |=> cpu_priority_level == $past(pend_lvl))
    else $error("level after trap ack wrong");
  a_msb_hw_only: assert property (
    $changed(cpu_priority_level[3]) |-> $past(core_ack) || $past(lvl_restore))
    else $error("level msb moved without core");
  // =====
  // Register read port
  a_read_idle: assert property (
    !$past(rd) |-> rdata == '0)
    else $error("read data outside read slot");
  a_unmapped_rd: assert property (
    $past(rd) && $past(addr) > IDX_CORE |-> rdata == '0)
    else $error("unmapped read not zero");
  c_user_ack: cover property (core_ack && pend_valid && pend_vec >= 7'h08);
  c_trap: cover property (pend_valid && pend_vec < 7'h08);
  c_restore: cover property (lvl_restore);
endmodule : vic_checker_sva

bind vic_controller vic_checker_sva #(.IRQ_COUNT(IRQ_COUNT)) u_vic_checker_sva (
  .clk(clk), .nrst(nrst), .addr(addr), .rd(rd), .rdata(rdata), .core_ack(core_ack),
  .lvl_restore(lvl_restore), .pend_valid(pend_valid), .pend_vec(pend_vec), .pend_lvl(pend_lvl),
  .pend_addr(pend_addr), .cpu_priority_level(cpu_priority_level));

// ---- vic_core_model.sv ----
`timescale 1ns/10ps
module vic_core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pend_valid,
  input wire logic ack_on,
  input wire logic [3:0] dly,
  output logic core_ack
);
  logic [3:0] cnt_reg;
  // =====
  // Takes the vector after dly cycles; dly of 0 is not allowed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      core_ack <= pend_valid && ack_on && !core_ack && cnt_reg == dly - 4'h1;
      cnt_reg <= (pend_valid && ack_on && !core_ack) ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule : vic_core_model

// ---- vic_controller_bench.sv ----
`timescale 1ns/10ps
module vic_controller_bench import vic_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_IRQ-1:0] irq_set = '0;
  logic [EXT_N-1:0] ext_pin = '0;
  logic [TRAP_N-1:0] trap_set = '0;
  logic disi_active = 1'b0;
  logic core_ack;
  logic lvl_restore = 1'b0;
  logic [LVL_W-1:0] lvl_restore_val = '0;
  logic pend_valid;
  logic [VEC_W-1:0] pend_vec;
  logic [LVL_W-1:0] pend_lvl;
  logic [TADDR_W-1:0] pend_addr;
  logic [LVL_W-1:0] cpu_priority_level;
  logic ack_on = 1'b0;
  logic [3:0] dly = 4'h1;
  int fails = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  vic_controller u_vic_controller (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq_set(irq_set), .ext_pin(ext_pin), .trap_set(trap_set),
    .disi_active(disi_active), .core_ack(core_ack), .lvl_restore(lvl_restore),
    .lvl_restore_val(lvl_restore_val), .pend_valid(pend_valid), .pend_vec(pend_vec),
    .pend_lvl(pend_lvl), .pend_addr(pend_addr), .cpu_priority_level(cpu_priority_level));
  vic_core_model u_vic_core_model (.clk(clk), .nrst(nrst), .pend_valid(pend_valid),
    .ack_on(ack_on), .dly(dly), .core_ack(core_ack));
  // =====
  // Helpers
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("read data", 24'(rdata), 24'(exp));
  endtask : rreg
  task automatic pres(input logic [6:0] vec, input logic [3:0] lvl, input logic alt);
    chk("valid", 24'(pend_valid), 24'h1);
    chk("vector", 24'(pend_vec), 24'(vec));
    chk("level", 24'(pend_lvl), 24'(lvl));
    chk("address", pend_addr, TBL_BASE + 24'({vec, 1'b0}) + (alt ? ALT_OFS : 24'h0));
  endtask : pres
  task automatic pulse(input int n);
    @(posedge clk);
    irq_set[n] <= 1'b1;
    @(posedge clk);
    irq_set <= '0;
    tick(1);
  endtask : pulse
  task automatic take(input logic [3:0] lvl);
    for (int i = 0; i < 20 && core_ack !== 1'b1; i++) tick(1);
    @(posedge clk);
    ack_on <= 1'b0;
    #1 chk("level after ack", 24'(cpu_priority_level), 24'(lvl));
  endtask : take
  task automatic restore(input logic [3:0] lvl);
    @(posedge clk);
    lvl_restore_val <= lvl;
    lvl_restore <= 1'b1;
    @(posedge clk);
    lvl_restore <= 1'b0;
    tick(1);
    chk("level restored", 24'(cpu_priority_level), 24'(lvl));
  endtask : restore
  // =====
  // Scenarios
  task automatic s_reset;
    rreg(IDX_CORE, CORE_RST);
    rreg(IDX_GCTL1, GCTL_RST);
    wreg(IDX_CORE, CORE_RST | 16'h0008);
    rreg(IDX_CORE, CORE_RST);
    wreg(6'h3F, 16'hFFFF);
    rreg(6'h3F, 16'h0000);
  endtask : s_reset
  task automatic s_map;
    int t[7] = '{46, IRQ_CODEC_ERR, IRQ_CODEC_DONE, IRQ_SER1_ERR, IRQ_SER2_ERR, IRQ_CAN1_TX, IRQ_CAN2_TX};
    for (int i = 0; i < 7; i++) begin
      wreg(IDX_GCTL2, {i[0], 15'h0});
      wreg(IDX_EN0 + 6'(t[i] / 16), 16'h1 << (t[i] % 16));
      wreg(IDX_PRIO0 + 6'(t[i] / 4), 16'h4 << ((t[i] % 4) * 4));
      pulse(t[i]);
      pres(7'(t[i] + 8), 4'h4, i[0]);
      rreg(IDX_PEND, 16'(t[i] + 8) | 16'h0400);
      rreg(IDX_FLAG0 + 6'(t[i] / 16), 16'h1 << (t[i] % 16));
      wreg(IDX_FLAG0 + 6'(t[i] / 16), 16'h0);
      wreg(IDX_EN0 + 6'(t[i] / 16), 16'h0);
    end
    wreg(IDX_GCTL2, 16'h0);
  endtask : s_map
  task automatic s_prio_ack;
    wreg(IDX_PRIO0 + 6'h0B, 16'h5500);
    wreg(IDX_EN0 + 6'h02, 16'hC000);
    pulse(46);
    pulse(47);
    pres(7'h36, 4'h5, 1'b0);
    wreg(IDX_PRIO0 + 6'h0B, 16'h6500);
    tick(1);
    pres(7'h37, 4'h6, 1'b0);
    wreg(IDX_STATUS, 16'h00C0);
    tick(1);
    chk("masked", 24'(pend_valid), 24'h0);
    wreg(IDX_PRIO0 + 6'h0B, 16'h7500);
    wreg(IDX_STATUS, 16'h00E0);
    tick(1);
    chk("masked at 7", 24'(pend_valid), 24'h0);
    wreg(IDX_STATUS, 16'h0000);
    tick(1);
    ack_on <= 1'b1;
    take(4'h7);
    restore(4'h0);
    wreg(IDX_PRIO0 + 6'h0B, 16'h3500);
    tick(1);
    dly <= 4'h4;
    ack_on <= 1'b1;
    take(4'h5);
    dly <= 4'h1;
    wreg(IDX_PRIO0 + 6'h0B, 16'h6500);
    tick(1);
    pres(7'h37, 4'h6, 1'b0);
    wreg(IDX_GCTL1, 16'h8000);
    ack_on <= 1'b1;
    take(4'h7);
    wreg(IDX_STATUS, 16'h0000);
    rreg(IDX_STATUS, 16'h00E0);
    wreg(IDX_GCTL1, 16'h0000);
    wreg(IDX_STATUS, 16'h0040);
    rreg(IDX_STATUS, 16'h0040);
  endtask : s_prio_ack
  task automatic s_trap;
    wreg(IDX_GCTL2, 16'h8000);
    for (int i = 0; i < TRAP_N; i++) begin
      @(posedge clk);
      trap_set[i] <= 1'b1;
      @(posedge clk);
      trap_set <= '0;
      tick(1);
      pres(7'(TRAP_VEC0 + i), TRAP_LVL[i], 1'b1);
      rreg(IDX_GCTL1, 16'h1 << TRAP_BIT[i]);
      ack_on <= 1'b1;
      take(TRAP_LVL[i]);
      wreg(IDX_GCTL1, 16'h0000);
      restore(4'h0);
    end
    wreg(IDX_FLAG0 + 6'h02, 16'h0000);
    wreg(IDX_GCTL2, 16'h0000);
  endtask : s_trap
  task automatic s_ext;
    wreg(IDX_EN0, 16'h0001);
    wreg(IDX_PRIO0, 16'h0001);
    @(posedge clk);
    ext_pin[0] <= 1'b1;
    tick(5);
    pres(7'h08, 4'h1, 1'b0);
    wreg(IDX_FLAG0, 16'h0000);
    wreg(IDX_GCTL2, 16'h0001);
    ext_pin[0] <= 1'b0;
    tick(5);
    rreg(IDX_FLAG0, 16'h0001);
    wreg(IDX_FLAG0, 16'h0000);
    ext_pin[0] <= 1'b1;
    disi_active <= 1'b1;
    tick(5);
    rreg(IDX_FLAG0, 16'h0000);
    rreg(IDX_GCTL2, 16'h4001);
  endtask : s_ext
  task automatic end_of_test;
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    s_reset;
    s_map;
    s_prio_ack;
    s_trap;
    s_ext;
    end_of_test;
  end
  initial begin
    #30000;
    fails++;
    end_of_test;
  end
endmodule : vic_controller_bench
